// [logic/function_enable_config.sv]
// Function enable register, per-function gating and floppy/IDE select logic.
// Assumes the address register and peripherals live outside and report hits.
`timescale 1ns/1ps
module function_enable_config (
  input wire logic sys_clk_i,
  input wire logic rst_b_i,
  input wire logic [7:0] strap_fer_i,
  input wire logic [7:0] cfg_index_i,
  input wire logic cfg_wr_i,
  input wire logic cfg_rd_i,
  input wire logic [7:0] cfg_wdata_i,
  output logic [7:0] cfg_rdata_o,
  input wire logic [15:0] io_addr_i,
  input wire logic io_wr_i,
  input wire logic io_rd_i,
  input wire logic par_range_hit_i,
  input wire logic uart1_range_hit_i,
  input wire logic uart2_range_hit_i,
  input wire logic [7:0] dor_i,
  input wire logic [7:0] power_mgmt_ctrl_reg_i,
  output logic [7:0] function_enable_reg_o,
  output logic par_clk_en_o,
  output logic uart1_clk_en_o,
  output logic uart2_clk_en_o,
  output logic fdc_clk_en_o,
  output logic ide_clk_en_o,
  output logic par_access_o,
  output logic uart1_access_o,
  output logic uart2_access_o,
  output logic fdc_access_o,
  output logic dor_latch_o,
  output logic drive_select_0_b_o,
  output logic drive_select_1_b_o,
  output logic motor_enable_0_b_o,
  output logic motor_enable_1_b_o,
  output logic hcs0_b_o,
  output logic hcs1_b_o,
  output logic hcs_oe_o,
  output logic ide_high_byte_enable_b_o,
  output logic ide_low_byte_enable_b_o,
  output logic ide_data_bit7_oe_o
);
  import function_enable_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // enable register

  logic [7:0] fer_q;
  logic [7:0] fer_d;
  logic strap_pend_q;
  logic [7:0] rdata_q;
  logic fer_sel;

  assign fer_sel = (cfg_index_i == FER_INDEX);

  // straps are caught one edge after reset release, never under reset itself
  always_ff @(posedge sys_clk_i) begin
    if (!rst_b_i) begin
      strap_pend_q <= 1'b1;
    end else begin
      strap_pend_q <= 1'b0;
    end
  end

  always_comb begin
    fer_d = fer_q;
    if (strap_pend_q) begin
      fer_d = strap_fer_i;
    end else if (cfg_wr_i && fer_sel) begin
      fer_d = cfg_wdata_i;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (!rst_b_i) begin
      fer_q <= FER_RESET;
    end else begin
      fer_q <= fer_d;
    end
  end

  // other indices belong to other registers and read as zero here
  always_ff @(posedge sys_clk_i) begin
    if (!rst_b_i) begin
      rdata_q <= 8'h00;
    end else if (cfg_rd_i) begin
      rdata_q <= fer_sel ? fer_q : 8'h00;
    end
  end

  assign cfg_rdata_o = rdata_q;
  assign function_enable_reg_o = fer_q;

  ////////////////////////////////////////////////////////////////////////////
  // clock gating and access blocking

  logic [4:0] clk_en_q;
  logic [3:0] access_q;

  always_ff @(posedge sys_clk_i) begin
    if (!rst_b_i) begin
      clk_en_q <= 5'h00;
    end else begin
      clk_en_q <= {fer_q[FER_IDE], fer_q[FER_FDC], fer_q[FER_UART2],
                   fer_q[FER_UART1], fer_q[FER_PAR]};
    end
  end

  assign par_clk_en_o = clk_en_q[0];
  assign uart1_clk_en_o = clk_en_q[1];
  assign uart2_clk_en_o = clk_en_q[2];
  assign fdc_clk_en_o = clk_en_q[3];
  assign ide_clk_en_o = clk_en_q[4];

  logic io_cyc;
  logic [15:0] fdc_base;
  logic fdc_hit;

  assign io_cyc = io_wr_i | io_rd_i;
  assign fdc_base = fer_q[FER_FDC_SEC] ? FDC_SEC_BASE : FDC_PRI_BASE;
  assign fdc_hit = (io_addr_i[15:3] == fdc_base[15:3]);

  always_ff @(posedge sys_clk_i) begin
    if (!rst_b_i) begin
      access_q <= 4'h0;
    end else begin
      access_q[0] <= io_cyc & par_range_hit_i & fer_q[FER_PAR];
      access_q[1] <= io_cyc & uart1_range_hit_i & fer_q[FER_UART1];
      access_q[2] <= io_cyc & uart2_range_hit_i & fer_q[FER_UART2];
      access_q[3] <= io_cyc & fdc_hit & fer_q[FER_FDC];
    end
  end

  assign par_access_o = access_q[0];
  assign uart1_access_o = access_q[1];
  assign uart2_access_o = access_q[2];
  assign fdc_access_o = access_q[3];

  ////////////////////////////////////////////////////////////////////////////
  // floppy drive select and motor pins (active low)

  logic dor_latch_q;
  logic [3:0] drv_q;
  logic [3:0] drv_d;
  logic [1:0] dsel;
  logic [3:0] motors;

  assign dsel = dor_i[1:0];
  assign motors = dor_i[DOR_MOTOR0 +: 4];

  always_ff @(posedge sys_clk_i) begin
    if (!rst_b_i) begin
      dor_latch_q <= 1'b0;
    end else begin
      dor_latch_q <= io_wr_i & fdc_hit & (io_addr_i[2:0] == FDC_DOR_OFS);
    end
  end

  assign dor_latch_o = dor_latch_q;

  // drv_d packs {motor1, motor0, select1, select0}
  always_comb begin
    drv_d = 4'hf;
    if (fer_q[FER_ENCODE]) begin
      drv_d[1:0] = dsel;
      drv_d[2] = ~motors[dsel];
      // motor1 has no meaning in this mode; parked inactive
      drv_d[3] = 1'b1;
    end else begin
      drv_d[0] = ~(dsel == 2'd0);
      drv_d[1] = ~(dsel == 2'd1);
      drv_d[2] = ~motors[0];
      drv_d[3] = ~motors[1];
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (!rst_b_i) begin
      drv_q <= 4'hf;
    end else begin
      drv_q <= drv_d;
    end
  end

  assign drive_select_0_b_o = drv_q[0];
  assign drive_select_1_b_o = drv_q[1];
  assign motor_enable_0_b_o = drv_q[2];
  assign motor_enable_1_b_o = drv_q[3];

  ////////////////////////////////////////////////////////////////////////////
  // IDE chip selects and byte enables (active low)

  logic [15:0] ide_cmd;
  logic [15:0] ide_ctl;
  logic cmd_hit;
  logic ctl_hit;
  logic ide_on;
  logic [5:0] ide_q;

  assign ide_cmd = fer_q[FER_IDE_SEC] ? IDE_SEC_CMD : IDE_PRI_CMD;
  assign ide_ctl = fer_q[FER_IDE_SEC] ? IDE_SEC_CTL : IDE_PRI_CTL;
  assign cmd_hit = io_cyc & (io_addr_i[15:3] == ide_cmd[15:3]);
  assign ctl_hit = io_cyc & (io_addr_i[15:1] == ide_ctl[15:1]);
  assign ide_on = fer_q[FER_IDE];

  // ide_q packs {d7_oe, hi_b, lo_b, oe, hcs1_b, hcs0_b}
  always_ff @(posedge sys_clk_i) begin
    if (!rst_b_i) begin
      ide_q <= 6'h1f;
    end else if (ide_on) begin
      ide_q[0] <= ~cmd_hit;
      ide_q[1] <= ~ctl_hit;
      ide_q[2] <= 1'b1;
      ide_q[3] <= ~(cmd_hit | ctl_hit);
      ide_q[4] <= ~(cmd_hit & (io_addr_i[2:0] == IDE_DATA_OFS));
      // this block drives bit 7 on reads of the odd control-block address only
      ide_q[5] <= ctl_hit & io_rd_i & io_addr_i[0];
    end else begin
      ide_q[0] <= 1'b1;
      ide_q[1] <= 1'b1;
      ide_q[2] <= ~power_mgmt_ctrl_reg_i[PMC_HCS_FLOAT];
      // byte enables off, data bit 7 floats
      ide_q[3] <= 1'b1;
      ide_q[4] <= 1'b1;
      ide_q[5] <= 1'b0;
    end
  end

  assign hcs0_b_o = ide_q[0];
  assign hcs1_b_o = ide_q[1];
  assign hcs_oe_o = ide_q[2];
  assign ide_low_byte_enable_b_o = ide_q[3];
  assign ide_high_byte_enable_b_o = ide_q[4];
  assign ide_data_bit7_oe_o = ide_q[5];

  ////////////////////////////////////////////////////////////////////////////
  // assertions

  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!rst_b_i);

  fer_write_a: assert property (
    cfg_wr_i && cfg_index_i == 8'h00 && !strap_pend_q
    |=> fer_q == $past(cfg_wdata_i))
    else $error("enable register missed a write at index 00h");

  fer_hold_a: assert property (
    !cfg_wr_i && !strap_pend_q |=> $stable(fer_q))
    else $error("enable register changed without a write");

  fer_read_a: assert property (
    cfg_rd_i && cfg_index_i == 8'h00 |=> cfg_rdata_o == $past(fer_q))
    else $error("read of index 00h did not return register value");

  clk_gate_a: assert property (
    !fer_q[3] ##1 !fer_q[3] |-> !fdc_clk_en_o)
    else $error("floppy clock running while disabled");

  uart1_block_a: assert property (
    !fer_q[1] |=> !uart1_access_o)
    else $error("first UART reached while disabled");

  uart2_block_a: assert property (
    !fer_q[2] |=> !uart2_access_o)
    else $error("second UART reached while disabled");

  fdc_decode_a: assert property (
    fer_q[3] && !fer_q[5] && io_rd_i && io_addr_i == 16'h03f5 |=> fdc_access_o)
    else $error("floppy primary access not decoded");

  dor_strobe_a: assert property (
    io_wr_i && fer_q[5] && io_addr_i == 16'h0372 |=> dor_latch_o)
    else $error("latch strobe missing for secondary write");

  enc_drive0_a: assert property (
    fer_q[4] && dor_i[1:0] == 2'b00 && dor_i[4]
    |=> !motor_enable_0_b_o && !drive_select_1_b_o && !drive_select_0_b_o)
    else $error("encoded drive 0 pins wrong");

  enc_drive1_a: assert property (
    fer_q[4] && dor_i[1:0] == 2'b01 && dor_i[5]
    |=> !motor_enable_0_b_o && !drive_select_1_b_o && drive_select_0_b_o)
    else $error("encoded drive 1 pins wrong");

  enc_drive2_a: assert property (
    fer_q[4] && dor_i[1:0] == 2'b10 && dor_i[6]
    |=> !motor_enable_0_b_o && drive_select_1_b_o && !drive_select_0_b_o)
    else $error("encoded drive 2 pins wrong");

  par_block_a: assert property (
    !fer_q[0] |=> !par_access_o)
    else $error("parallel port reached while disabled");

  enc_drive3_a: assert property (
    fer_q[4] && dor_i[1:0] == 2'b11 && !dor_i[7]
    |=> motor_enable_0_b_o && drive_select_1_b_o && drive_select_0_b_o)
    else $error("encoded drive 3 motor off pins wrong");

  direct_drive_a: assert property (
    !fer_q[4] && dor_i[1:0] == 2'b01 && dor_i[5]
    |=> drive_select_0_b_o && !drive_select_1_b_o && !motor_enable_1_b_o)
    else $error("direct drive 1 pins wrong");

  ide_off_a: assert property (
    !fer_q[6] |=> ide_low_byte_enable_b_o && ide_high_byte_enable_b_o
    && !ide_data_bit7_oe_o && hcs0_b_o && hcs1_b_o)
    else $error("IDE pins active while disabled");

  hcs_float_a: assert property (
    !fer_q[6] |=> hcs_oe_o == !$past(power_mgmt_ctrl_reg_i[0]))
    else $error("chip select drive ignores power control bit");

  ide_sec_a: assert property (
    fer_q[6] && fer_q[7] && io_wr_i && io_addr_i == 16'h0377 |=> !hcs1_b_o)
    else $error("secondary control block not selected");

  enc_mode_c: cover property (fer_q[4] && dor_i[1:0] == 2'b10 ##1 !motor_enable_0_b_o);
  ide_pri_c: cover property (fer_q[6] && !fer_q[7] ##1 !hcs0_b_o);
  uart_off_c: cover property (fer_q[1] ##1 !fer_q[1]);
  dor_pri_c: cover property (dor_latch_o && !fer_q[5]);
  hcs_float_c: cover property (!fer_q[6] && power_mgmt_ctrl_reg_i[0] ##1 !hcs_oe_o);
endmodule

// [logic/function_enable_pkg.sv]
// Constants for the function enable configuration register and its decode.
// Assumes host cycles arrive already synchronous to sys_clk_i as one-cycle strobes.
// Function
// - enable register sits at configuration index 00h of the index/data pair
// - clock enable of each function drops while its enable bit is clear
// - bit 0 set lets host reach parallel port at address-register range
// - bit 1 set decodes host accesses to first UART
// - bit 1 clear blocks first UART and holds it powered down, registers kept
// - bit 2 gates second UART access and power-down likewise
// - bit 3 gates floppy controller at address picked by bit 5
// - bit 4 clear drives two selects and two motors directly
// - bit 4 set encodes selects and motors for an external four-drive decoder
// - encoded drive 0 with motor 0 on gives motor0, sel1, sel0 all low
// - encoded drive 1 with motor 1 on gives motor0 0, sel 0,1
// - encoded drive 2 with motor 2 on gives motor0 0, sel 1,0
// - encoded drive 3 gives sel 1,1; motor0 high when selected motor off
// - bit 5 picks primary or secondary floppy address range
// - latch strobe follows writes to 3F2h (bit 5 low) or 372h (high)
// - bit 6 set makes IDE reachable at range picked by bit 7
// - bit 6 clear: power control bit 0 picks inactive or floating chip selects
// - IDE disabled keeps byte enables inactive and floats data bit 7
// - bit 7 picks primary or secondary IDE address range
// - IDE primary 1F0-7h, 3F6-7h; secondary 170-7h, 376-7h
package function_enable_pkg;
  localparam logic [7:0] FER_INDEX = 8'h00;
  localparam logic [7:0] FER_RESET = 8'h00;
  localparam int FER_PAR = 0;
  localparam int FER_UART1 = 1;
  localparam int FER_UART2 = 2;
  localparam int FER_FDC = 3;
  localparam int FER_ENCODE = 4;
  localparam int FER_FDC_SEC = 5;
  localparam int FER_IDE = 6;
  localparam int FER_IDE_SEC = 7;
  localparam int DOR_MOTOR0 = 4;
  localparam logic [15:0] FDC_PRI_BASE = 16'h03f0;
  localparam logic [15:0] FDC_SEC_BASE = 16'h0370;
  localparam logic [2:0] FDC_DOR_OFS = 3'h2;
  localparam logic [15:0] IDE_PRI_CMD = 16'h01f0;
  localparam logic [15:0] IDE_SEC_CMD = 16'h0170;
  localparam logic [15:0] IDE_PRI_CTL = 16'h03f6;
  localparam logic [15:0] IDE_SEC_CTL = 16'h0376;
  localparam logic [2:0] IDE_DATA_OFS = 3'h0;
  localparam int PMC_HCS_FLOAT = 0;
endpackage

// [verif/floppy_drive_decoder.sv]
// External four-drive decoder model behind the encoded select and motor pins.
// Assumes encoded mode; pins are the raw levels of the block's active-low outputs.
`timescale 1ns/1ps
module floppy_drive_decoder (
  input wire logic drive_select_0_b_i,
  input wire logic drive_select_1_b_i,
  input wire logic motor_enable_0_b_i,
  output logic [3:0] drive_on_o,
  output logic [3:0] motor_on_o
);
  logic [1:0] sel;
  assign sel = {drive_select_1_b_i, drive_select_0_b_i};
  // one drive only
  // a select code enables exactly one drive; the motor line only ever adds that drive's motor
  assign drive_on_o = 4'h1 << sel;
  assign motor_on_o = motor_enable_0_b_i ? 4'h0 : drive_on_o;
endmodule

// [verif/function_enable_config_bench.sv]
// Self-checking bench for the function enable register and its decode.
// Assumes the design registers every output one edge after its cause.
`timescale 1ns/1ps
module function_enable_config_bench;
  import function_enable_pkg::*;
  logic sys_clk = 1'b0, rst_b = 1'b0, wr = 1'b0, rd = 1'b0, iow = 1'b0, ior = 1'b0;
  logic [7:0] strap = 8'h4f, idx = 8'h00, wdata = 8'h00, rdata, dor = 8'h00, power_mgmt_ctrl_reg = 8'h00, function_enable;
  logic [15:0] addr = 16'h0000;
  logic hp = 1'b1, hu1 = 1'b1, hu2 = 1'b1;
  logic cp, cu1, cu2, cf, ci, ap, au1, au2, af, lat, ds0, ds1, me0, me1;
  logic h0, h1, hoe, hi_b, lo_b, d7;
  logic [3:0] drv_on, mot_on;
  int error_cnt = 0;
  int n_tests = 0;
  always #2.5 sys_clk = ~sys_clk;
  function_enable_config i_dut (.sys_clk_i(sys_clk), .rst_b_i(rst_b), .strap_fer_i(strap),
    .cfg_index_i(idx), .cfg_wr_i(wr), .cfg_rd_i(rd), .cfg_wdata_i(wdata), .cfg_rdata_o(rdata),
    .io_addr_i(addr), .io_wr_i(iow), .io_rd_i(ior), .par_range_hit_i(hp),
    .uart1_range_hit_i(hu1), .uart2_range_hit_i(hu2), .dor_i(dor),
    .power_mgmt_ctrl_reg_i(power_mgmt_ctrl_reg), .function_enable_reg_o(function_enable), .par_clk_en_o(cp),
    .uart1_clk_en_o(cu1), .uart2_clk_en_o(cu2), .fdc_clk_en_o(cf), .ide_clk_en_o(ci),
    .par_access_o(ap), .uart1_access_o(au1), .uart2_access_o(au2), .fdc_access_o(af),
    .dor_latch_o(lat), .drive_select_0_b_o(ds0), .drive_select_1_b_o(ds1),
    .motor_enable_0_b_o(me0), .motor_enable_1_b_o(me1), .hcs0_b_o(h0), .hcs1_b_o(h1),
    .hcs_oe_o(hoe), .ide_high_byte_enable_b_o(hi_b), .ide_low_byte_enable_b_o(lo_b),
    .ide_data_bit7_oe_o(d7));
  floppy_drive_decoder i_dec (.drive_select_0_b_i(ds0), .drive_select_1_b_i(ds1),
    .motor_enable_0_b_i(me0), .drive_on_o(drv_on), .motor_on_o(mot_on));
  ////////////////////////////////////////////////////////////////////////////
  task automatic end_sim;
    if (error_cnt == 0 && n_tests > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    n_tests++;
    if (got !== exp) begin
      error_cnt++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic cfg_wr(input logic [7:0] i, input logic [7:0] d);
    @(posedge sys_clk) idx <= i;
    wdata <= d;
    wr <= 1'b1;
    @(posedge sys_clk) wr <= 1'b0;
  endtask
  task automatic cfg_rd(input logic [7:0] i, output logic [7:0] d);
    @(posedge sys_clk) idx <= i;
    rd <= 1'b1;
    @(posedge sys_clk) rd <= 1'b0;
    #1 d = rdata;
  endtask
  // one host strobe; outputs are looked at in the single cycle they stand
  task automatic io(input logic [15:0] a, input logic w);
    @(posedge sys_clk) addr <= a;
    iow <= w;
    ior <= !w;
    @(posedge sys_clk) iow <= 1'b0;
    ior <= 1'b0;
    #1;
  endtask
  task automatic settle;
    repeat (3) @(posedge sys_clk);
    #1;
  endtask
  ////////////////////////////////////////////////////////////////////////////
  task automatic t_reg;
    logic [7:0] d;
    chk("strap", 8'h4f, function_enable);
    cfg_wr(FER_INDEX, 8'ha5);
    cfg_rd(FER_INDEX, d);
    chk("readback", 8'ha5, d);
    cfg_wr(8'h01, 8'h3c);
    settle();
    chk("other index", 8'ha5, function_enable);
    cfg_rd(8'h01, d);
    chk("other read", 8'h00, d);
  endtask
  task automatic t_clocks;
    cfg_wr(FER_INDEX, 8'h0a);
    settle();
    chk("clk en a", 8'h0a, {3'h0, ci, cf, cu2, cu1, cp});
    cfg_wr(FER_INDEX, 8'h45);
    settle();
    chk("clk en b", 8'h15, {3'h0, ci, cf, cu2, cu1, cp});
  endtask
  task automatic t_access;
    cfg_wr(FER_INDEX, 8'h0a);
    io(16'h03f5, 1'b0);
    chk("access a", 8'h0a, {4'h0, af, au2, au1, ap});
    cfg_wr(FER_INDEX, 8'h25);
    io(16'h0375, 1'b0);
    chk("access b", 8'h05, {4'h0, af, au2, au1, ap});
    @(posedge sys_clk) hp <= 1'b0;
    hu2 <= 1'b0;
    io(16'h0375, 1'b0);
    chk("access no hit", 8'h00, {4'h0, af, au2, au1, ap});
    hp <= 1'b1;
    hu2 <= 1'b1;
    cfg_wr(FER_INDEX, 8'h28);
    io(16'h03f5, 1'b0);
    chk("fdc pri off", 8'h00, {7'h0, af});
    io(16'h0375, 1'b0);
    chk("fdc sec", 8'h01, {7'h0, af});
  endtask
  task automatic t_latch;
    cfg_wr(FER_INDEX, 8'h00);
    io(16'h03f2, 1'b1);
    chk("latch pri", 8'h01, {7'h0, lat});
    io(16'h0372, 1'b1);
    chk("latch pri other", 8'h00, {7'h0, lat});
    cfg_wr(FER_INDEX, 8'h20);
    io(16'h0372, 1'b1);
    chk("latch sec", 8'h01, {7'h0, lat});
    io(16'h03f2, 1'b1);
    chk("latch sec other", 8'h00, {7'h0, lat});
  endtask
  task automatic t_drives;
    cfg_wr(FER_INDEX, 8'h00);
    dor <= 8'h21;
    settle();
    chk("direct pins", 8'h05, {4'h0, me1, me0, ds1, ds0});
    cfg_wr(FER_INDEX, 8'h10);
    for (int s = 0; s < 4; s++) begin
      for (int m = 0; m < 2; m++) begin
        dor <= 8'((m << (DOR_MOTOR0 + s)) | s);
        settle();
        chk("enc sel", 8'(s), {6'h0, ds1, ds0});
        chk("enc motor", 8'(1 - m), {7'h0, me0});
        chk("dec drive", 8'(1 << s), {4'h0, drv_on});
        chk("dec motor", 8'(m << s), {4'h0, mot_on});
      end
    end
  endtask
  task automatic t_ide;
    power_mgmt_ctrl_reg <= 8'h00;
    cfg_wr(FER_INDEX, 8'h40);
    io(16'h01f0, 1'b1);
    chk("ide pri data", 8'h04, {4'h0, h0, h1, lo_b, hi_b});
    io(16'h03f7, 1'b0);
    chk("ide pri ctl", 8'h09, {4'h0, h0, h1, lo_b, hi_b});
    chk("ide d7", 8'h01, {7'h0, d7});
    cfg_wr(FER_INDEX, 8'hc0);
    io(16'h0170, 1'b1);
    chk("ide sec data", 8'h04, {4'h0, h0, h1, lo_b, hi_b});
    io(16'h01f0, 1'b1);
    chk("ide sec miss", 8'h0f, {4'h0, h0, h1, lo_b, hi_b});
    power_mgmt_ctrl_reg <= 8'h01;
    cfg_wr(FER_INDEX, 8'h00);
    io(16'h01f0, 1'b1);
    chk("ide off float", 8'h06, {4'h0, hoe, lo_b, hi_b, d7});
    power_mgmt_ctrl_reg <= 8'h00;
    io(16'h03f7, 1'b0);
    chk("ide off drive", 8'h1f, {3'h0, h0, h1, hoe, lo_b, hi_b});
    chk("ide off d7", 8'h00, {7'h0, d7});
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (20) @(posedge sys_clk);
    chk("reset reg", 8'h00, function_enable);
    chk("reset pins", 8'hfb, {lo_b, hi_b, h0, h1, hoe, d7, me0, ds0});
    rst_b <= 1'b1;
    settle();
    t_reg();
    t_clocks();
    t_access();
    t_latch();
    t_drives();
    t_ide();
    end_sim();
  end
  // whole run is about 120 cycles; this leaves wide margin
  initial begin
    #20000;
    error_cnt++;
    end_sim();
  end
endmodule
